// file: rtl/hsw_window.sv
// Host-visible runtime registers of the shared memory window: two mailboxes,
// a dword window into controller memory, host event source/mask and owner tag.
// Assumes host and controller ports are synchronous to core_clk_in and that
// the controller memory answers each request with a one-cycle ack.
// Function
// - Host write to inbound mailbox stores it and pulses an event to controller.
// - Controller may clear any subset of inbound mailbox bits.
// - Controller write to outbound mailbox stores it and pulses an event to host.
// - Host clears outbound mailbox bits by writing ones.
// - Host and controller views of each mailbox share one storage.
// - Low address bits 7:2 give offset 7:2; offset 1:0 always zero.
// - Width field selects auto-32, 32, 16 or 8-bit window access.
// - High address bits 6:0 give offset bits 14:8.
// - High address bit 7 selects segment one or zero base.
// - Memory address is segment base plus dword offset.
// - Data bytes 0..3 form one 32-bit word, byte 0 least significant.
// - Controller sets source bits; host write-one clears them.
// - Host clear ignored where controller clear permission bit is zero.
// - Source bit 0 flags controller mailbox write, read-only, never reaches the host interrupt.
// - Mask ones let matching source bits raise the host interrupt.
// - Owner tag at zero accepts any written value.
// - Owner tag non-zero clears when same value written.
// - Owner tag non-zero ignores any different value.
// - Host and controller reach registers at fixed offsets.
// - 32-bit: read byte 0 loads dword, write byte 3 stores dword.
// - Auto-increment: byte 3 access advances offset to next dword, except a write out of bounds.
// - 16-bit: bytes 0/2 load halfwords, bytes 1/3 store halfwords.
// - Out-of-bounds writes keep memory; no-access reads keep the data register.
`timescale 1ns/1ps
`include "hsw_params.svh"

module hsw_window (
	input wire logic core_clk_in, // 125 MHz system clock
	input wire logic sys_rst_in, // Synchronous reset, active high
	input wire logic host_valid_in, // Host register request
	input wire hsw_pkg::hsw_hreq_t host_req_in, // Host request fields
	output logic host_ready_out, // Host request may be taken
	output logic host_ack_out, // Host request done, one cycle
	output logic [7:0] host_rdata_out, // Host read data
	output logic host_irq_out, // Masked host event level
	output logic outbox_evt_out, // Outbound mail written, pulse
	input wire logic ec_valid_in, // Controller register request
	input wire hsw_pkg::hsw_ereq_t ec_req_in, // Controller request fields
	output logic ec_ack_out, // Controller request done, pulse
	output logic [31:0] ec_rdata_out, // Controller read data
	output logic inbox_evt_out, // Inbound mail written, pulse
	output logic mem_req_out, // Memory request, held to ack
	output hsw_pkg::hsw_mreq_t mem_cmd_out, // Memory command
	input wire logic mem_ack_in, // Memory done, one cycle
	input wire logic [31:0] mem_rdata_in // Memory read data on ack
);
	import hsw_pkg::*;

	hsw_state_t state_q, state_d;
	hsw_hreq_t hreq_q;
	logic [7:0] inbox_q, outbox_q, owner_q;
	logic outbox_flag_q;
	logic [15:1] src_q;
	logic [15:0] mask_q;
	logic [15:1] clr_en_q;
	logic [12:0] offs_q;
	logic [1:0] width_q;
	logic region_q;
	logic [29:0] base0_q, base1_q;
	logic [12:0] rlim0_q, wlim0_q, rlim1_q, wlim1_q;
	logic [31:0] data_q, data_wr, data_ld;
	logic h_wr, h_rd, h_data, mem_done;
	logic e_wr;
	logic dec_go, dec_step;
	logic [3:0] dec_be;
	logic [31:0] dec_addr;
	logic [7:0] reg_rd;
	logic [31:0] ec_rd;
	logic [1:0] lane;

	// ======================================================================
	// Request strobes
	// Host work is done in the EXEC cycle from the latched request
	assign h_wr = (state_q == HSW_ST_EXEC) && hreq_q.we;
	assign h_rd = (state_q == HSW_ST_EXEC) && !hreq_q.we;
	assign h_data = hreq_q.addr[3:2] == 2'b01;
	assign lane = hreq_q.addr[1:0];
	assign mem_done = (state_q == HSW_ST_MEM) && mem_ack_in;
	assign e_wr = ec_valid_in && ec_req_in.we;

	hsw_win_decode u_dec (
		.width_in(width_q),
		.lane_in(lane),
		.we_in(hreq_q.we),
		.offs_in(offs_q),
		.region_in(region_q),
		.base0_in(base0_q),
		.base1_in(base1_q),
		.rlim0_in(rlim0_q),
		.wlim0_in(wlim0_q),
		.rlim1_in(rlim1_q),
		.wlim1_in(wlim1_q),
		.mem_go_out(dec_go),
		.be_out(dec_be),
		.step_out(dec_step),
		.maddr_out(dec_addr)
	);

	// ======================================================================
	// Data word lanes: host byte write and memory load merge
	// four bytes, one word
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign data_wr[8*i +: 8] = (h_data && lane == i) ? hreq_q.wdata : data_q[8*i +: 8];
		assign data_ld[8*i +: 8] = mem_cmd_out.be[i] ? mem_rdata_in[8*i +: 8] : data_q[8*i +: 8];
	end

	// ======================================================================
	// Host request sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			HSW_ST_IDLE: begin
				if (host_valid_in) begin
					state_d = HSW_ST_EXEC;
				end
			end
			HSW_ST_EXEC: begin
				state_d = (h_data && dec_go) ? HSW_ST_MEM : HSW_ST_IDLE;
			end
			HSW_ST_MEM: begin
				if (mem_ack_in) begin
					state_d = HSW_ST_IDLE;
				end
			end
			default: begin
				state_d = HSW_ST_IDLE;
			end
		endcase
	end

	// Requests are taken only while idle; ready tells the host so
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_q <= HSW_ST_IDLE;
			host_ready_out <= 1'b1;
			hreq_q <= '0;
		end else begin
			state_q <= state_d;
			host_ready_out <= state_d == HSW_ST_IDLE;
			if (state_q == HSW_ST_IDLE && host_valid_in) begin
				hreq_q <= host_req_in;
			end
		end
	end

	// ======================================================================
	// Memory port; command is frozen while the request is outstanding
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mem_req_out <= 1'b0;
			mem_cmd_out <= '0;
		end else if (state_q == HSW_ST_EXEC && h_data && dec_go) begin
			mem_req_out <= 1'b1;
			mem_cmd_out <= '{we: hreq_q.we, addr: dec_addr, be: dec_be, wdata: data_wr};
		end else if (mem_done) begin
			mem_req_out <= 1'b0;
		end
	end

	// ======================================================================
	// Data register
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			data_q <= `HSW_RST32;
		end else if (h_wr && h_data) begin
			// register updates even if memory stays
			data_q <= data_wr;
		end else if (mem_done && !mem_cmd_out.we) begin
			data_q <= data_ld;
		end
	end

	// ======================================================================
	// Window offset, width and segment
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			offs_q <= `HSW_RST_OFF;
			width_q <= `HSW_W_8;
			region_q <= 1'b0;
		end else if (h_wr && hreq_q.addr == `HSW_OFF_ADDR_LO) begin
			offs_q[5:0] <= hreq_q.wdata[7:2];
			width_q <= hreq_q.wdata[1:0];
		end else if (h_wr && hreq_q.addr == `HSW_OFF_ADDR_HI) begin
			offs_q[12:6] <= hreq_q.wdata[6:0];
			region_q <= hreq_q.wdata[`HSW_REGION_BIT];
		end else if ((state_q == HSW_ST_EXEC && h_data && dec_step && !dec_go)
				|| (mem_done && dec_step)) begin
			offs_q <= offs_q + 13'h0001;
		end
	end

	// ======================================================================
	// Mailboxes; one copy each, seen from both sides
	// shared mailbox storage
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			inbox_q <= `HSW_RST8;
		end else if (h_wr && hreq_q.addr == `HSW_OFF_INBOX) begin
			inbox_q <= hreq_q.wdata;
		end else if (e_wr && ec_req_in.addr == `HSW_EC_INBOX) begin
			inbox_q <= inbox_q & ~ec_req_in.wdata[7:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			outbox_q <= `HSW_RST8;
		end else if (e_wr && ec_req_in.addr == `HSW_EC_OUTBOX) begin
			outbox_q <= ec_req_in.wdata[7:0];
		end else if (h_wr && hreq_q.addr == `HSW_OFF_OUTBOX) begin
			outbox_q <= outbox_q & ~hreq_q.wdata;
		end
	end

	// Mail events; pulses so each write is one notification
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			inbox_evt_out <= 1'b0;
			outbox_evt_out <= 1'b0;
		end else begin
			inbox_evt_out <= h_wr && hreq_q.addr == `HSW_OFF_INBOX;
			outbox_evt_out <= e_wr && ec_req_in.addr == `HSW_EC_OUTBOX;
		end
	end

	// Written flag: set wins over the clear made by a host read of the outbox
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			outbox_flag_q <= 1'b0;
		end else if (e_wr && ec_req_in.addr == `HSW_EC_OUTBOX) begin
			outbox_flag_q <= 1'b1;
		end else if (h_rd && hreq_q.addr == `HSW_OFF_OUTBOX) begin
			outbox_flag_q <= 1'b0;
		end
	end

	// ======================================================================
	// Host event sources, mask and interrupt
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			src_q <= 15'h0000;
		end else begin
			// gated host clear, then controller set wins
			src_q <= (src_q & ~(clr_en_q
					& ((h_wr && hreq_q.addr == `HSW_OFF_SRC_LO) ? {8'h00, hreq_q.wdata[7:1]} : 15'h0000)
					& ((h_wr && hreq_q.addr == `HSW_OFF_SRC_HI) ? {hreq_q.wdata, 7'h00} : 15'h0000)
					| clr_en_q
					& ((h_wr && hreq_q.addr == `HSW_OFF_SRC_HI) ? {hreq_q.wdata, 7'h00} : 15'h0000)
					| clr_en_q
					& ((h_wr && hreq_q.addr == `HSW_OFF_SRC_LO) ? {8'h00, hreq_q.wdata[7:1]} : 15'h0000)))
				| ((e_wr && ec_req_in.addr == `HSW_EC_SET) ? ec_req_in.wdata[15:1] : 15'h0000);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mask_q <= `HSW_RST16;
			host_irq_out <= 1'b0;
		end else begin
			if (h_wr && hreq_q.addr == `HSW_OFF_MASK_LO) begin
				mask_q[7:0] <= hreq_q.wdata;
			end
			if (h_wr && hreq_q.addr == `HSW_OFF_MASK_HI) begin
				mask_q[15:8] <= hreq_q.wdata;
			end
			host_irq_out <= |(src_q & mask_q[15:1]);
		end
	end

	// ======================================================================
	// Owner tag claim and release
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			owner_q <= `HSW_RST8;
		end else if (h_wr && hreq_q.addr == `HSW_OFF_OWNER) begin
			if (owner_q == `HSW_RST8) begin
				owner_q <= hreq_q.wdata;
			end else if (owner_q == hreq_q.wdata) begin
				owner_q <= `HSW_RST8;
			end
		end
	end

	// ======================================================================
	// Controller-only configuration
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			base0_q <= 30'h0000_0000;
			base1_q <= 30'h0000_0000;
			rlim0_q <= `HSW_RST_OFF;
			wlim0_q <= `HSW_RST_OFF;
			rlim1_q <= `HSW_RST_OFF;
			wlim1_q <= `HSW_RST_OFF;
			clr_en_q <= 15'h0000;
		end else if (e_wr) begin
			unique case (ec_req_in.addr)
				`HSW_EC_BASE0: base0_q <= ec_req_in.wdata[31:2];
				`HSW_EC_BASE1: base1_q <= ec_req_in.wdata[31:2];
				`HSW_EC_RLIM0: rlim0_q <= ec_req_in.wdata[14:2];
				`HSW_EC_WLIM0: wlim0_q <= ec_req_in.wdata[14:2];
				`HSW_EC_RLIM1: rlim1_q <= ec_req_in.wdata[14:2];
				`HSW_EC_WLIM1: wlim1_q <= ec_req_in.wdata[14:2];
				`HSW_EC_CLR_EN: clr_en_q <= ec_req_in.wdata[15:1];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Read multiplexers
	// host offsets
	always_comb begin
		unique case (hreq_q.addr)
			`HSW_OFF_INBOX: reg_rd = inbox_q;
			`HSW_OFF_OUTBOX: reg_rd = outbox_q;
			`HSW_OFF_ADDR_LO: reg_rd = {offs_q[5:0], width_q};
			`HSW_OFF_ADDR_HI: reg_rd = {region_q, offs_q[12:6]};
			`HSW_OFF_DATA_B0: reg_rd = data_q[7:0];
			`HSW_OFF_DATA_B1: reg_rd = data_q[15:8];
			`HSW_OFF_DATA_B2: reg_rd = data_q[23:16];
			`HSW_OFF_DATA_B3: reg_rd = data_q[31:24];
			`HSW_OFF_SRC_LO: reg_rd = {src_q[7:1], outbox_flag_q};
			`HSW_OFF_SRC_HI: reg_rd = src_q[15:8];
			`HSW_OFF_MASK_LO: reg_rd = mask_q[7:0];
			`HSW_OFF_MASK_HI: reg_rd = mask_q[15:8];
			`HSW_OFF_OWNER: reg_rd = owner_q;
			default: reg_rd = `HSW_RST8;
		endcase
	end

	always_comb begin
		unique case (ec_req_in.addr)
			`HSW_EC_INBOX: ec_rd = {24'h000000, inbox_q};
			`HSW_EC_OUTBOX: ec_rd = {24'h000000, outbox_q};
			`HSW_EC_BASE0: ec_rd = {base0_q, 2'b00};
			`HSW_EC_BASE1: ec_rd = {base1_q, 2'b00};
			`HSW_EC_RLIM0: ec_rd = {17'h00000, rlim0_q, 2'b00};
			`HSW_EC_WLIM0: ec_rd = {17'h00000, wlim0_q, 2'b00};
			`HSW_EC_RLIM1: ec_rd = {17'h00000, rlim1_q, 2'b00};
			`HSW_EC_WLIM1: ec_rd = {17'h00000, wlim1_q, 2'b00};
			`HSW_EC_SET: ec_rd = {16'h0000, src_q, 1'b0};
			`HSW_EC_CLR_EN: ec_rd = {16'h0000, clr_en_q, 1'b0};
			default: ec_rd = `HSW_RST32;
		endcase
	end

	// ======================================================================
	// Answers; memory loads return the freshly merged byte
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			host_ack_out <= 1'b0;
			host_rdata_out <= `HSW_RST8;
		end else begin
			host_ack_out <= (state_q == HSW_ST_EXEC && !(h_data && dec_go)) || mem_done;
			if (h_rd && !(h_data && dec_go)) begin
				host_rdata_out <= reg_rd;
			end else if (mem_done && !mem_cmd_out.we) begin
				host_rdata_out <= data_ld[8*lane +: 8];
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ec_ack_out <= 1'b0;
			ec_rdata_out <= `HSW_RST32;
		end else begin
			ec_ack_out <= ec_valid_in;
			if (ec_valid_in && !ec_req_in.we) begin
				ec_rdata_out <= ec_rd;
			end
		end
	end

endmodule : hsw_window

// file: rtl/hsw_params.svh
// Holds the offsets, field positions, reset values and access-width codes
// of the shared memory window block.
// Assumes it is included by bare name from the design files that need it.
`ifndef HSW_PARAMS_SVH
`define HSW_PARAMS_SVH

// ==========================================================================
// Host-visible register offsets
`define HSW_OFF_INBOX 4'h0
`define HSW_OFF_OUTBOX 4'h1
`define HSW_OFF_ADDR_LO 4'h2
`define HSW_OFF_ADDR_HI 4'h3
`define HSW_OFF_DATA_B0 4'h4
`define HSW_OFF_DATA_B1 4'h5
`define HSW_OFF_DATA_B2 4'h6
`define HSW_OFF_DATA_B3 4'h7
`define HSW_OFF_SRC_LO 4'h8
`define HSW_OFF_SRC_HI 4'h9
`define HSW_OFF_MASK_LO 4'hA
`define HSW_OFF_MASK_HI 4'hB
`define HSW_OFF_OWNER 4'hC

// ==========================================================================
// Controller-only register offsets
`define HSW_EC_INBOX 9'h100
`define HSW_EC_OUTBOX 9'h101
`define HSW_EC_BASE0 9'h104
`define HSW_EC_RLIM0 9'h108
`define HSW_EC_WLIM0 9'h10A
`define HSW_EC_BASE1 9'h10C
`define HSW_EC_RLIM1 9'h110
`define HSW_EC_WLIM1 9'h112
`define HSW_EC_SET 9'h114
`define HSW_EC_CLR_EN 9'h116

// ==========================================================================
// Access-width codes and field positions
`define HSW_W_AUTO 2'h3
`define HSW_W_32 2'h2
`define HSW_W_16 2'h1
`define HSW_W_8 2'h0
`define HSW_REGION_BIT 7
`define HSW_LANE_HI 2'h3
`define HSW_BE_ALL 4'hF
`define HSW_BE_LO_HALF 4'h3
`define HSW_BE_HI_HALF 4'hC
`define HSW_BE_ONE 4'h1

// ==========================================================================
// Reset values
`define HSW_RST8 8'h00
`define HSW_RST16 16'h0000
`define HSW_RST32 32'h0000_0000
`define HSW_RST_OFF 13'h0000

`endif

// file: rtl/hsw_pkg.sv
// Holds the types shared by the shared memory window block, its checker, memory model and bench.
// Assumes the constants header is compiled alongside.
package hsw_pkg;

	// ======================================================================
	// Host request sequencer states, Gray along the usual path
	typedef enum logic [1:0] {
		HSW_ST_IDLE = 2'b00,
		HSW_ST_EXEC = 2'b01,
		HSW_ST_MEM = 2'b11
	} hsw_state_t;

	// ======================================================================
	// Request carriers
	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic [7:0] wdata;
	} hsw_hreq_t;

	typedef struct packed {
		logic we;
		logic [8:0] addr;
		logic [31:0] wdata;
	} hsw_ereq_t;

	typedef struct packed {
		logic we;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} hsw_mreq_t;

endpackage : hsw_pkg

// file: rtl/hsw_win_decode.sv
// Decodes one data-window access into a memory operation, byte enables,
// target address and auto-increment step.
// Assumes region bases and limits are held stable by the enclosing block.
`timescale 1ns/1ps
`include "hsw_params.svh"

module hsw_win_decode (
	input wire logic [1:0] width_in, // Access width code
	input wire logic [1:0] lane_in, // Data byte addressed
	input wire logic we_in, // Host write when high
	input wire logic [12:0] offs_in, // Window offset bits 14:2
	input wire logic region_in, // Segment select
	input wire logic [29:0] base0_in, // Segment zero base 31:2
	input wire logic [29:0] base1_in, // Segment one base 31:2
	input wire logic [12:0] rlim0_in, // Segment zero read limit
	input wire logic [12:0] wlim0_in, // Segment zero write limit
	input wire logic [12:0] rlim1_in, // Segment one read limit
	input wire logic [12:0] wlim1_in, // Segment one write limit
	output logic mem_go_out, // Memory operation needed
	output logic [3:0] be_out, // Byte enables
	output logic step_out, // Advance offset afterwards
	output logic [31:0] maddr_out // Dword address in memory
);
	logic in_rd;
	logic in_wr;
	logic trig;

	// ======================================================================
	// Bounds: a region at or above its limit is read-only or no-access
	// bounds gate memory
	assign in_rd = offs_in < (region_in ? rlim1_in : rlim0_in);
	assign in_wr = offs_in < (region_in ? wlim1_in : wlim0_in);

	assign maddr_out = {(region_in ? base1_in : base0_in), 2'b00} + {17'h00000, offs_in, 2'b00};

	// Which lane fires memory, per width code
	always_comb begin
		trig = 1'b0;
		be_out = `HSW_BE_ALL;
		unique case (width_in)
			`HSW_W_8: begin
				trig = 1'b1;
				be_out = `HSW_BE_ONE << lane_in;
			end
			`HSW_W_16: begin
				trig = we_in ? lane_in[0] : ~lane_in[0];
				be_out = lane_in[1] ? `HSW_BE_HI_HALF : `HSW_BE_LO_HALF;
			end
			`HSW_W_32, `HSW_W_AUTO: begin
				trig = we_in ? (lane_in == `HSW_LANE_HI) : (lane_in == 2'h0);
				be_out = `HSW_BE_ALL;
			end
		endcase
	end

	assign mem_go_out = trig & (we_in ? in_wr : in_rd);

	// step on byte 3; reads step even out of bounds, writes do not
	assign step_out = (width_in == `HSW_W_AUTO) && (lane_in == `HSW_LANE_HI) && (!we_in || in_wr);

endmodule : hsw_win_decode

// file: sim/hsw_window_chk.sv
// Port checker for the shared memory window block.
// Assumes it is bound to hsw_window and sees only that module's ports.
`timescale 1ns/1ps

module hsw_window_chk import hsw_pkg::*; (
	input wire logic core_clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic host_valid_in, // Host valid
	input wire hsw_pkg::hsw_hreq_t host_req_in, // Host request
	input wire logic host_ready_out, // Host ready
	input wire logic host_ack_out, // Host done
	input wire logic [7:0] host_rdata_out, // Host data
	input wire logic host_irq_out, // Host event
	input wire logic outbox_evt_out, // Outbound pulse
	input wire logic ec_valid_in, // Controller strobe
	input wire hsw_pkg::hsw_ereq_t ec_req_in, // Controller request
	input wire logic ec_ack_out, // Controller done
	input wire logic [31:0] ec_rdata_out, // Controller data
	input wire logic inbox_evt_out, // Inbound pulse
	input wire logic mem_req_out, // Memory request
	input wire hsw_pkg::hsw_mreq_t mem_cmd_out, // Memory command
	input wire logic mem_ack_in, // Memory done
	input wire logic [31:0] mem_rdata_in // Memory data
);
	logic taken;
	logic no_mem;
	logic wr0;
	logic ewr1;

	// ==========
	// Request decode, so each property stays on one line
	assign taken = host_valid_in && host_ready_out;
	assign no_mem = host_req_in.addr < 4'h4 || host_req_in.addr > 4'h7;
	assign wr0 = taken && host_req_in.we && host_req_in.addr == 4'h0;
	assign ewr1 = ec_valid_in && ec_req_in.we && ec_req_in.addr == 9'h101;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	// ==========
	// Host and controller ports
	a_host_ack_two: assert property (taken && no_mem |-> ##2 host_ack_out)
		else $error("host ack not two cycles after request");
	a_ready_drops: assert property (taken |=> !host_ready_out)
		else $error("host ready stayed high");
	a_inbox_pulse: assert property (wr0 |-> ##2 inbox_evt_out ##1 !inbox_evt_out)
		else $error("inbound event pulse wrong");
	a_outbox_pulse: assert property (ewr1 |=> outbox_evt_out)
		else $error("outbound event missing");
	a_ec_ack: assert property (ec_valid_in |=> ec_ack_out)
		else $error("controller ack missing");
	a_rdata_hold: assert property (!host_ack_out |-> $stable(host_rdata_out))
		else $error("host read data moved without ack");

	// ==========
	// Memory port
	a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_cmd_out))
		else $error("memory request dropped or changed");
	a_mem_release: assert property (mem_req_out && mem_ack_in |=> !mem_req_out && host_ack_out)
		else $error("memory completion wrong");
	a_mem_align: assert property (mem_req_out |-> mem_cmd_out.addr[1:0] == 2'b00)
		else $error("memory address not dword aligned");
	a_be_shape: assert property (mem_req_out |-> mem_cmd_out.be inside {4'hF, 4'h3, 4'hC,
		4'h1, 4'h2, 4'h4, 4'h8})
		else $error("illegal byte enables");

	c_mem_done: cover property (mem_req_out && mem_ack_in);
	c_outbox: cover property (outbox_evt_out);
	c_irq: cover property ($rose(host_irq_out));
endmodule : hsw_window_chk

// file: sim/hsw_mem_model.sv
// Behavioural controller memory for the window's memory port.
// Assumes one outstanding request; slow_in adds three wait cycles.
`timescale 1ns/1ps

module hsw_mem_model import hsw_pkg::*; (
	input wire logic core_clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic slow_in, // Slow answers
	input wire logic mem_req_in, // Request level
	input wire hsw_pkg::hsw_mreq_t mem_cmd_in, // Command
	output logic mem_ack_out, // One-cycle done
	output logic [31:0] mem_rdata_out // Read data
);
	logic [31:0] mem_q [16];
	logic [31:0] last_addr_q;
	logic [1:0] cnt_q;
	logic [3:0] idx;

	// ==========
	// Sixteen dwords, aliased by address bits 5:2
	assign idx = mem_cmd_in.addr[5:2];
	// Outside the ack cycle the data is inverted so stale lanes never match
	assign mem_rdata_out = mem_ack_out ? mem_q[idx] : ~mem_q[idx];

	// Wait count, write merge by byte enable, last address for the bench
	always_ff @(posedge core_clk_in) begin
		mem_ack_out <= 1'b0;
		if (sys_rst_in) begin
			cnt_q <= 2'h0;
			last_addr_q <= 32'h0;
			for (int i = 0; i < 16; i++) mem_q[i] <= 32'h1020_3040 + 32'h0101_0101 * 32'(i);
		end else if (mem_req_in && !mem_ack_out) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == (slow_in ? 2'h3 : 2'h0)) begin
				cnt_q <= 2'h0;
				mem_ack_out <= 1'b1;
				last_addr_q <= mem_cmd_in.addr;
				for (int b = 0; b < 4; b++)
					if (mem_cmd_in.we && mem_cmd_in.be[b]) mem_q[idx][8*b +: 8] <= mem_cmd_in.wdata[8*b +: 8];
			end
		end
	end
endmodule : hsw_mem_model

// file: sim/hsw_window_tb_top.sv
// Self-checking bench for the shared memory window register block.
// Assumes the memory model answers the window's memory port.
`timescale 1ns/1ps

module hsw_window_tb_top;
	import hsw_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hv = 1'b0;
	hsw_hreq_t hq = '0;
	logic ev = 1'b0;
	hsw_ereq_t eq = '0;
	logic slow = 1'b0;
	logic rdy, hack, irq, oevt, eack, ievt, mreq, mack;
	logic [7:0] hrd;
	logic [31:0] erd, mrd, rv, w;
	hsw_mreq_t mcmd;
	logic [7:0] own_w [4] = '{8'h37, 8'h12, 8'h37, 8'h5C};
	logic [7:0] own_e [4] = '{8'h37, 8'h37, 8'h00, 8'h5C};
	int n_mismatch = 0;
	int tests_run = 0;

	hsw_window u_dut (.core_clk_in(clk), .sys_rst_in(rst), .host_valid_in(hv),
		.host_req_in(hq), .host_ready_out(rdy), .host_ack_out(hack), .host_rdata_out(hrd),
		.host_irq_out(irq), .outbox_evt_out(oevt), .ec_valid_in(ev), .ec_req_in(eq),
		.ec_ack_out(eack), .ec_rdata_out(erd), .inbox_evt_out(ievt), .mem_req_out(mreq),
		.mem_cmd_out(mcmd), .mem_ack_in(mack), .mem_rdata_in(mrd));

	hsw_mem_model u_mem (.core_clk_in(clk), .sys_rst_in(rst), .slow_in(slow),
		.mem_req_in(mreq), .mem_cmd_in(mcmd), .mem_ack_out(mack), .mem_rdata_out(mrd));

	initial begin
		forever #4 clk = ~clk;
	end

	// ==========
	// Access tasks and comparison
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// Request held until an edge that sees ready, then wait for the ack
	task automatic hacc(input logic we, input logic [3:0] a, input logic [7:0] d);
		logic r;
		int n;
		@(posedge clk);
		hv <= 1'b1;
		hq <= '{we, a, d};
		do begin
			@(negedge clk);
			r = rdy;
			@(posedge clk);
		end while (r !== 1'b1);
		hv <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (hack !== 1'b1 && n < 40);
		chk("host ack", 32'h1, {31'h0, hack});
		rv = {24'h0, hrd};
	endtask : hacc

	task automatic hget(input logic [3:0] a, input logic [7:0] e);
		hacc(1'b0, a, 8'h00);
		chk("host read", {24'h0, e}, rv);
	endtask : hget

	task automatic ecacc(input logic we, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		ev <= 1'b1;
		eq <= '{we, a, d};
		@(posedge clk);
		ev <= 1'b0;
		@(negedge clk);
		chk("ctrl ack", 32'h1, {31'h0, eack});
		rv = erd;
	endtask : ecacc

	task automatic results();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// Generous bound: about seventy-five accesses of under ten cycles each
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end

	// ==========
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 14; a++) hget(a[3:0], 8'h00);
		// Mailboxes from both sides
		hacc(1'b1, 4'h0, 8'hA5);
		ecacc(1'b0, 9'h100, 32'h0);
		chk("ctrl inbox", 32'hA5, rv);
		ecacc(1'b1, 9'h100, 32'h21);
		hget(4'h0, 8'h84);
		ecacc(1'b1, 9'h101, 32'h5A);
		hget(4'h8, 8'h01);
		hget(4'h1, 8'h5A);
		hget(4'h8, 8'h00);
		hacc(1'b1, 4'h1, 8'h0F);
		hget(4'h1, 8'h50);
		// Event sources, clear permission and mask
		ecacc(1'b1, 9'h116, 32'h0004);
		ecacc(1'b1, 9'h114, 32'h0106);
		hacc(1'b1, 4'hA, 8'h02);
		hget(4'h9, 8'h01);
		chk("irq on", 32'h1, {31'h0, irq});
		hacc(1'b1, 4'h8, 8'h06);
		hget(4'h8, 8'h02);
		hacc(1'b1, 4'hA, 8'h04);
		hget(4'hA, 8'h04);
		chk("irq off", 32'h0, {31'h0, irq});
		// Owner tag claims
		for (int i = 0; i < 4; i++) begin
			hacc(1'b1, 4'hC, own_w[i]);
			hget(4'hC, own_e[i]);
		end
		// Segment one base, limits of three and four dwords in segment zero
		ecacc(1'b1, 9'h10C, 32'h20);
		ecacc(1'b1, 9'h108, 32'h10);
		ecacc(1'b1, 9'h10A, 32'h0C);
		ecacc(1'b1, 9'h110, 32'h7FFC);
		ecacc(1'b1, 9'h112, 32'h7FFC);
		hacc(1'b1, 4'h2, 8'h06);
		w = u_mem.mem_q[1];
		for (int b = 0; b < 4; b++) hget(4'h4 + b[3:0], w[8*b +: 8]);
		chk("mem addr", 32'h4, u_mem.last_addr_q);
		@(posedge clk);
		slow <= 1'b1;
		hacc(1'b1, 4'h2, 8'h0A);
		w = u_mem.mem_q[2];
		for (int b = 0; b < 3; b++) hacc(1'b1, 4'h4 + b[3:0], 8'h11 * (b[7:0] + 8'h1));
		chk("mem kept", w, u_mem.mem_q[2]);
		hacc(1'b1, 4'h7, 8'h44);
		chk("mem dword", 32'h4433_2211, u_mem.mem_q[2]);
		hacc(1'b1, 4'h2, 8'h05);
		w = u_mem.mem_q[1];
		hacc(1'b1, 4'h6, 8'hEE);
		hacc(1'b1, 4'h7, 8'hFF);
		chk("mem half", {16'hFFEE, w[15:0]}, u_mem.mem_q[1]);
		hget(4'h4, w[7:0]);
		hacc(1'b1, 4'h2, 8'h00);
		w = u_mem.mem_q[0];
		hacc(1'b1, 4'h5, 8'h77);
		chk("mem byte", {w[31:16], 8'h77, w[7:0]}, u_mem.mem_q[0]);
		hget(4'h6, w[23:16]);
		// Auto step through segment one at offset bits above bit 7
		hacc(1'b1, 4'h3, 8'h81);
		hacc(1'b1, 4'h2, 8'h07);
		for (int k = 0; k < 2; k++) begin
			hget(4'h4, u_mem.mem_q[9 + k][7:0]);
			chk("mem addr", 32'h124 + 32'(4 * k), u_mem.last_addr_q);
			hget(4'h7, u_mem.mem_q[9 + k][31:24]);
		end
		// Writes beyond the write limit and reads beyond the read limit
		hacc(1'b1, 4'h3, 8'h00);
		hacc(1'b1, 4'h2, 8'h0E);
		w = u_mem.mem_q[3];
		hacc(1'b1, 4'h4, 8'hC3);
		hacc(1'b1, 4'h7, 8'h3C);
		chk("mem guard", w, u_mem.mem_q[3]);
		hacc(1'b1, 4'h2, 8'h16);
		hget(4'h4, 8'hC3);
		results();
	end
endmodule : hsw_window_tb_top

bind hsw_window hsw_window_chk u_chk (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
	.host_valid_in(host_valid_in), .host_req_in(host_req_in), .host_ready_out(host_ready_out),
	.host_ack_out(host_ack_out), .host_rdata_out(host_rdata_out), .host_irq_out(host_irq_out),
	.outbox_evt_out(outbox_evt_out), .ec_valid_in(ec_valid_in), .ec_req_in(ec_req_in),
	.ec_ack_out(ec_ack_out), .ec_rdata_out(ec_rdata_out), .inbox_evt_out(inbox_evt_out),
	.mem_req_out(mem_req_out), .mem_cmd_out(mem_cmd_out), .mem_ack_in(mem_ack_in),
	.mem_rdata_in(mem_rdata_in));
